// file: pkg/twi_target_pkg.sv
package twi_target_pkg;

    // ------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------
    localparam int BYTE_BITS = 8;
    localparam int ADDR_BITS = 7;
    localparam logic [3:0] BIT_CNT_ZERO = 4'h0;
    localparam logic [3:0] BIT_CNT_FULL = 4'h8;
    localparam logic DIR_WRITE = 1'b0;
    localparam logic DIR_READ = 1'b1;
    localparam logic [7:0] SHIFT_RESET = 8'h00;
    localparam logic [6:0] OWN_ADDR_DEFAULT = 7'h3B;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int DATA_SETUP_NS = 250;
    localparam int SETUP_CYC_INT = (DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] SETUP_CYC = SETUP_CYC_INT[3:0];
    localparam logic [3:0] SETUP_ZERO = 4'h0;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic scl;
        logic sda;
    } lines_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_WR_DATA,
        ST_WR_ACK,
        ST_TX_WAIT,
        ST_RD_DATA,
        ST_RD_ACK
    } tgt_state_t;

endpackage

// file: verilog/twi_target.sv
`timescale 1ns/1ps

// Behaviour
// - Each byte is eight data bits plus one acknowledge bit.
// - Bytes shift most significant bit first; every byte gets an acknowledge slot.
// - A receiver may hold the clock low; transmitter resumes after release.
// - START is data falling while clock is high.
// - STOP is data rising while clock is high.
// - First byte carries seven address bits then a direction bit.
// - Direction zero means master writes; one means master reads.
// - Data changes only while clock is low, except START and STOP.
// - Master clocks the acknowledge slot; transmitter releases data there.
// - Acknowledging receiver holds data low through the acknowledge pulse.
// - Unaddressed slave leaves data high; master then sends STOP.
// - Slave transmitter releases data after master's not-acknowledge.
module twi_target
    import twi_target_pkg::*;
#(
    parameter logic [6:0] OWN_ADDR = OWN_ADDR_DEFAULT
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    output logic tx_taken,
    output logic [7:0] rx_data,
    output logic rx_valid,
    input wire logic rx_ready,
    output logic selected,
    output logic bus_busy
);

    // ------------------------------------------------------------
    // Line synchronisers and condition detection
    // ------------------------------------------------------------
    lines_t meta_r;
    lines_t sync_r;
    lines_t prev_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_r <= '{scl: 1'b1, sda: 1'b1};
            sync_r <= '{scl: 1'b1, sda: 1'b1};
            prev_r <= '{scl: 1'b1, sda: 1'b1};
        end else begin
            meta_r <= '{scl: scl_i, sda: sda_i};
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;

    assign scl_rise = sync_r.scl && !prev_r.scl;
    assign scl_fall = !sync_r.scl && prev_r.scl;
    assign start_det = sync_r.scl && prev_r.scl && prev_r.sda && !sync_r.sda;
    assign stop_det = sync_r.scl && prev_r.scl && !prev_r.sda && sync_r.sda;

    // ------------------------------------------------------------
    // Bus monitor
    // ------------------------------------------------------------
    logic busy_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_r <= 1'b0;
        end else if (start_det) begin
            busy_r <= 1'b1;
        end else if (stop_det) begin
            busy_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Frame engine
    // ------------------------------------------------------------
    tgt_state_t state_r;
    logic [3:0] bit_cnt_r;
    logic [7:0] shift_r;
    logic dir_r;
    logic sel_r;
    logic sda_oe_r;
    logic scl_oe_r;
    logic [3:0] setup_r;
    logic [7:0] rx_data_r;
    logic rx_valid_r;
    logic tx_taken_r;
    logic low_r;
    logic [7:0] shift_nxt;

    assign shift_nxt = {shift_r[6:0], 1'b0};

    // Pad data level is always low; only the enables move
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            low_r <= 1'b0;
        end else begin
            low_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_IDLE;
            bit_cnt_r <= BIT_CNT_ZERO;
            shift_r <= SHIFT_RESET;
            dir_r <= DIR_WRITE;
            sel_r <= 1'b0;
            sda_oe_r <= 1'b0;
            scl_oe_r <= 1'b0;
            setup_r <= SETUP_ZERO;
            rx_data_r <= SHIFT_RESET;
            rx_valid_r <= 1'b0;
            tx_taken_r <= 1'b0;
        end else begin
            rx_valid_r <= 1'b0;
            tx_taken_r <= 1'b0;
            if (stop_det) begin
                state_r <= ST_IDLE;
                sel_r <= 1'b0;
                sda_oe_r <= 1'b0;
                scl_oe_r <= 1'b0;
            end else if (start_det) begin
                // Repeated START restarts addressing too
                state_r <= ST_ADDR;
                bit_cnt_r <= BIT_CNT_ZERO;
                sel_r <= 1'b0;
                sda_oe_r <= 1'b0;
                scl_oe_r <= 1'b0;
            end else begin
                unique case (state_r)
                    ST_IDLE: begin
                        sda_oe_r <= 1'b0;
                        scl_oe_r <= 1'b0;
                    end
                    ST_ADDR: begin
                        if (scl_rise) begin
                            shift_r <= {shift_r[6:0], sync_r.sda};
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                        end else if (scl_fall && bit_cnt_r == BIT_CNT_FULL) begin
                            dir_r <= shift_r[0];
                            if (shift_r[7:1] == OWN_ADDR) begin
                                sda_oe_r <= 1'b1;
                                sel_r <= 1'b1;
                                state_r <= ST_ADDR_ACK;
                            end else begin
                                state_r <= ST_IDLE;
                            end
                        end
                    end
                    ST_ADDR_ACK: begin
                        if (scl_fall) begin
                            sda_oe_r <= 1'b0;
                            bit_cnt_r <= BIT_CNT_ZERO;
                            if (dir_r == DIR_READ) begin
                                scl_oe_r <= 1'b1;
                                state_r <= ST_TX_WAIT;
                            end else begin
                                state_r <= ST_WR_DATA;
                            end
                        end
                    end
                    ST_WR_DATA: begin
                        // Stretch from the last acknowledge ends once the user can take a byte
                        if (scl_oe_r && rx_ready) begin
                            scl_oe_r <= 1'b0;
                        end
                        if (scl_rise) begin
                            shift_r <= {shift_r[6:0], sync_r.sda};
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                        end else if (scl_fall && bit_cnt_r == BIT_CNT_FULL) begin
                            rx_data_r <= shift_r;
                            rx_valid_r <= 1'b1;
                            sda_oe_r <= 1'b1;
                            state_r <= ST_WR_ACK;
                        end
                    end
                    ST_WR_ACK: begin
                        if (scl_fall) begin
                            sda_oe_r <= 1'b0;
                            bit_cnt_r <= BIT_CNT_ZERO;
                            scl_oe_r <= !rx_ready;
                            state_r <= ST_WR_DATA;
                        end
                    end
                    ST_TX_WAIT: begin
                        // Clock held low until a byte is ready and data has settled
                        if (setup_r != SETUP_ZERO) begin
                            setup_r <= setup_r - 4'h1;
                            if (setup_r == 4'h1) begin
                                scl_oe_r <= 1'b0;
                                state_r <= ST_RD_DATA;
                            end
                        end else if (tx_valid) begin
                            shift_r <= tx_data;
                            sda_oe_r <= !tx_data[BYTE_BITS - 1];
                            tx_taken_r <= 1'b1;
                            setup_r <= SETUP_CYC;
                        end
                    end
                    ST_RD_DATA: begin
                        if (scl_rise) begin
                            bit_cnt_r <= bit_cnt_r + 4'h1;
                        end else if (scl_fall) begin
                            if (bit_cnt_r == BIT_CNT_FULL) begin
                                sda_oe_r <= 1'b0;
                                state_r <= ST_RD_ACK;
                            end else begin
                                shift_r <= shift_nxt;
                                sda_oe_r <= !shift_nxt[BYTE_BITS - 1];
                            end
                        end
                    end
                    ST_RD_ACK: begin
                        if (scl_rise) begin
                            shift_r[0] <= sync_r.sda;
                        end else if (scl_fall) begin
                            bit_cnt_r <= BIT_CNT_ZERO;
                            if (!shift_r[0]) begin
                                scl_oe_r <= 1'b1;
                                state_r <= ST_TX_WAIT;
                            end else begin
                                sel_r <= 1'b0;
                                state_r <= ST_IDLE;
                            end
                        end
                    end
                endcase
            end
        end
    end

    assign scl_o = low_r;
    assign sda_o = low_r;
    assign scl_oe = scl_oe_r;
    assign sda_oe = sda_oe_r;
    assign tx_taken = tx_taken_r;
    assign rx_data = rx_data_r;
    assign rx_valid = rx_valid_r;
    assign selected = sel_r;
    assign bus_busy = busy_r;

endmodule

// file: verification/twi_target_checker.sv
`timescale 1ns/1ps
module twi_target_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic scl_oe,
    input wire logic sda_oe,
    input wire logic tx_valid,
    input wire logic tx_taken,
    input wire logic rx_valid,
    input wire logic rx_ready,
    input wire logic selected,
    input wire logic bus_busy
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    busy_set_a: assert property (scl_i && $past(scl_i) && $fell(sda_i) |-> ##[1:6] bus_busy)
        else $error("busy not set after start");
    busy_clr_a: assert property (scl_i && $past(scl_i) && $rose(sda_i) |-> ##[1:6] !bus_busy)
        else $error("busy not cleared after stop");
    idle_quiet_a: assert property (!bus_busy |-> !sda_oe && !scl_oe)
        else $error("lines driven on idle bus");
    sel_busy_a: assert property (selected |-> bus_busy)
        else $error("selected outside a transfer");
    sda_low_a: assert property ($changed(sda_oe) |-> !scl_i)
        else $error("data changed while clock high");
    rx_ack_a: assert property (rx_valid |=> !rx_valid && sda_oe)
        else $error("received byte not acknowledged");
    tx_pulse_a: assert property (tx_taken |-> $past(tx_valid) ##1 !tx_taken ##[5:7] !scl_oe)
        else $error("transmit hand-over or release wrong");
    stretch_a: assert property ($rose(rx_ready) && scl_oe |-> ##[1:2] !scl_oe)
        else $error("stretch not released");

    cover property (tx_taken);
    cover property (rx_valid);
    cover property ($fell(selected));
endmodule

bind twi_target twi_target_checker i_twi_target_checker (.clk(clk), .rst_n(rst_n),
    .scl_i(scl_i), .sda_i(sda_i), .scl_oe(scl_oe), .sda_oe(sda_oe), .tx_valid(tx_valid),
    .tx_taken(tx_taken), .rx_valid(rx_valid), .rx_ready(rx_ready), .selected(selected),
    .bus_busy(bus_busy));

// file: verification/twi_dev_model.sv
`timescale 1ns/1ps
module twi_dev_model (
    input wire logic scl,
    input wire logic sda,
    output logic scl_oe,
    output logic sda_oe,
    output logic hung,
    output logic lost
);
    // Timer unit; 32 ns keeps every wire change off the bench's rising edges
    localparam int UNIT = 32;
    initial begin
        scl_oe = 1'b0;
        sda_oe = 1'b0;
        hung = 1'b0;
        lost = 1'b0;
    end
    task automatic start();
        int n;
        n = 0;
        while (!(scl === 1'b1 && sda === 1'b1) && n < 500) begin
            #(UNIT) n++;
        end
        lost = 1'b0;
        sda_oe = 1'b1;
        #(4 * UNIT) scl_oe = 1'b1;
    endtask
    task automatic rstart();
        #(UNIT) sda_oe = 1'b0;
        #(5 * UNIT) scl_oe = 1'b0;
        #(4 * UNIT) sda_oe = 1'b1;
        #(4 * UNIT) scl_oe = 1'b1;
    endtask
    task automatic stop();
        #(UNIT) sda_oe = 1'b1;
        #(5 * UNIT) scl_oe = 1'b0;
        #(4 * UNIT) sda_oe = 1'b0;
        #(4 * UNIT);
    endtask
    task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
        int n;
        for (int i = 8; i >= 0; i--) begin
            #(UNIT) sda_oe = ~tx[i] && !lost;
            #(5 * UNIT) scl_oe = 1'b0;
            n = 0;
            while (scl !== 1'b1 && n < 500) begin
                #(UNIT) n++;
            end
            if (n >= 500) hung = 1'b1;
            #(2 * UNIT) rx[i] = sda;
            // A sending master that reads low where it left the line high has lost
            if (i > 0 && tx[8:1] != 8'hFF && tx[i] && !rx[i]) lost = 1'b1;
            #(2 * UNIT) scl_oe = 1'b1;
        end
    endtask
endmodule

// file: verification/twi_target_tb.sv
`timescale 1ns/1ps
module twi_target_tb;
    import twi_target_pkg::*;
    logic clk, rst_n, scl_oe, sda_oe, m_scl_oe, m_sda_oe, scl, sda, hung, lost;
    logic tx_valid, tx_taken, rx_valid, rx_ready, selected, bus_busy;
    logic [7:0] tx_data, rx_data;
    logic [8:0] got;
    int n_fail, num_checks, n_rx, n_tx;
    assign scl = ~(scl_oe | m_scl_oe);
    assign sda = ~(sda_oe | m_sda_oe);
    twi_target i_twi_target (.clk(clk), .rst_n(rst_n), .scl_i(scl), .scl_o(), .scl_oe(scl_oe),
        .sda_i(sda), .sda_o(), .sda_oe(sda_oe), .tx_data(tx_data), .tx_valid(tx_valid),
        .tx_taken(tx_taken), .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .selected(selected), .bus_busy(bus_busy));
    twi_dev_model i_dev (.scl(scl), .sda(sda), .scl_oe(m_scl_oe), .sda_oe(m_sda_oe), .hung(hung),
        .lost(lost));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (rx_valid === 1'b1) n_rx++;
        if (tx_taken === 1'b1) n_tx++;
    end
    always @(negedge clk) tx_data <= (n_tx == 0) ? 8'h3C : 8'hC3;
    task automatic check(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("CHECK FAILED at %0t: %s", $time, msg);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic write_stretch();
        i_dev.start();
        repeat (2) @(negedge clk);
        check(bus_busy === 1'b1, "busy after start");
        i_dev.xfer({OWN_ADDR_DEFAULT, DIR_WRITE, 1'b1}, got);
        check(got[0] === 1'b0 && selected === 1'b1, "address ack");
        @(negedge clk) rx_ready = 1'b0;
        i_dev.xfer({8'hA5, 1'b1}, got);
        check(got[0] === 1'b0 && rx_data === 8'hA5 && n_rx == 1, "write byte");
        check(lost === 1'b0, "write lost arbitration");
        repeat (6) @(negedge clk);
        check(scl_oe === 1'b1, "no stretch");
        rx_ready = 1'b1;
        repeat (2) @(negedge clk);
        check(scl_oe === 1'b0, "stretch kept");
        i_dev.stop();
        repeat (2) @(negedge clk);
        check(bus_busy === 1'b0 && selected === 1'b0, "busy after stop");
    endtask
    task automatic bad_addr();
        @(negedge clk) i_dev.start();
        i_dev.xfer({7'h15, DIR_WRITE, 1'b1}, got);
        check(got[0] === 1'b1 && selected === 1'b0, "foreign address acked");
        i_dev.stop();
    endtask
    task automatic read_rstart();
        @(negedge clk) tx_valid = 1'b1;
        i_dev.start();
        i_dev.xfer({OWN_ADDR_DEFAULT, DIR_WRITE, 1'b1}, got);
        i_dev.rstart();
        i_dev.xfer({OWN_ADDR_DEFAULT, DIR_READ, 1'b1}, got);
        check(got[0] === 1'b0 && lost === 1'b0, "read address ack");
        i_dev.xfer(9'h1FE, got);
        check(got[8:1] === 8'h3C, "first read byte");
        i_dev.xfer(9'h1FF, got);
        check(got[8:1] === 8'hC3 && n_tx == 2, "second read byte");
        repeat (6) @(negedge clk);
        check(sda_oe === 1'b0 && scl_oe === 1'b0, "lines held after nack");
        i_dev.stop();
        @(negedge clk) tx_valid = 1'b0;
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge hung) begin
        n_fail++;
        $display("CHECK FAILED at %0t: clock held low too long", $time);
        finish_test();
    end
    initial begin
        rst_n = 1'b0;
        rx_ready = 1'b1;
        tx_valid = 1'b0;
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        check(bus_busy === 1'b0 && sda_oe === 1'b0, "reset state");
        write_stretch();
        bad_addr();
        read_rstart();
        finish_test();
    end
    initial begin
        #2000000;
        n_fail++;
        $display("CHECK FAILED at %0t: timeout", $time);
        finish_test();
    end
endmodule
